// ===== core/diag_pkg.sv
package diag_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_DIAG_CONTROL = 4'h0;
	localparam logic [3:0] OFS_FRAME_STATUS = 4'h1;
	localparam logic [3:0] OFS_MODE_STATUS = 4'h2;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h4;
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'h5;

	// ------------------------------------------------------------
	// Control byte fields
	// ------------------------------------------------------------
	localparam int BIT_START = 0;
	localparam int BIT_RAM_SEL = 1;
	localparam int BIT_LOOP_SEL = 2;
	localparam int BIT_DMA_SEL = 3;
	localparam int BIT_ADDR_DRV = 4;
	localparam int BIT_DIAG_EN = 7;
	localparam logic [7:0] CTRL_USED_MASK = 8'h9F;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ------------------------------------------------------------
	// Interrupt bits
	// ------------------------------------------------------------
	localparam int IRQ_MODE_CHANGE = 0;
	localparam int IRQ_DIAG_DONE = 1;
	localparam int IRQ_WIDTH = 2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TEST_TIME_NS = 800;
	localparam int TEST_CYCLES = (TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Mode of the controller
	typedef enum logic [1:0] {
		MODE_ISOLATE = 2'b00,
		MODE_DIAG = 2'b01,
		MODE_LEAVING = 2'b10
	} mode_t;

	// Frame status flags carried together
	typedef struct packed {
		logic last_frame_flag;
		logic ack_pending_flag;
		logic short_frame_flag;
		logic [3:0] buffer_size_field;
	} frame_flags_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ===== core/diag_test_engine.sv
`timescale 1ns/1ns
`default_nettype none
// Runs one selected self-test for a fixed number of cycles
module diag_test_engine #(
	parameter int CYCLES = diag_pkg::TEST_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Control
	input wire logic go,
	input wire logic [2:0] sel,
	// Status
	output logic busy,
	output logic done
);
	logic [15:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;

	// Counter and completion pulse
	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (!busy_r && go && (sel != 3'b000)) begin
			busy_nxt = 1'b1;
			cnt_nxt = 16'(CYCLES - 1);
		end else if (!busy_r && go) begin
			done_nxt = 1'b1; // Nothing selected: finish at once
		end else if (busy_r) begin
			if (cnt_r == 16'h0000) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
endmodule // diag_test_engine
`default_nettype wire

// ===== core/diag_irq.sv
`timescale 1ns/1ns
`default_nettype none
// Sticky event bits, enable gating, one level output
module diag_irq #(
	parameter int N = diag_pkg::IRQ_WIDTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Events and software
	input wire logic [N-1:0] event_set,
	input wire logic [N-1:0] clear,
	input wire logic [N-1:0] enable,
	// Results
	output logic [N-1:0] status,
	output logic irq
);
	logic [N-1:0] status_r, status_nxt;
	logic irq_r, irq_nxt;

	// Set wins over a clear in the same cycle
	always_comb begin
		status_nxt = (status_r & ~clear) | event_set;
		irq_nxt = |(status_nxt & enable);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign status = status_r;
	assign irq = irq_r;
endmodule // diag_irq
`default_nettype wire

// ===== core/token_node_diag_control.sv
`timescale 1ns/1ns
`default_nettype none
module token_node_diag_control #(
	parameter int TEST_CYCLES = diag_pkg::TEST_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Frame engine flags
	input wire diag_pkg::frame_flags_t frame_flags,
	// Address bus
	input wire logic [15:0] addr_value,
	input wire logic dma_grant_ack_n,
	output logic [15:0] addr_out,
	output logic addr_oe_n,
	// Test status and interrupt
	output logic diag_state,
	output logic [2:0] test_running,
	output logic mode_change_irq
);
	// ------------------------------------------------------------
	// Control register and mode machine
	// ------------------------------------------------------------
	logic [7:0] ctrl_r, ctrl_nxt;
	diag_pkg::mode_t mode_r, mode_nxt;
	logic state_r, state_nxt;
	logic [2:0] run_sel_r, run_sel_nxt;
	logic go;
	logic eng_busy, eng_done;
	logic confirmed;
	logic [diag_pkg::IRQ_WIDTH-1:0] irq_set, irq_clr, irq_en_r, irq_en_nxt, irq_stat;
	logic irq_line;

	assign confirmed = ctrl_r[diag_pkg::BIT_DIAG_EN] & state_r;

	// Next control, mode and launch
	always_comb begin
		ctrl_nxt = ctrl_r;
		mode_nxt = mode_r;
		state_nxt = state_r;
		run_sel_nxt = run_sel_r;
		go = 1'b0;
		irq_set = '0;
		if (reg_wr && reg_addr == diag_pkg::OFS_DIAG_CONTROL) begin
			ctrl_nxt = reg_wdata & diag_pkg::CTRL_USED_MASK;
			// A start already running cannot be dropped by software
			if (ctrl_r[diag_pkg::BIT_START])
				ctrl_nxt[diag_pkg::BIT_START] = 1'b1;
		end
		// Start only honoured once mode is confirmed
		if (!confirmed && !ctrl_r[diag_pkg::BIT_START])
			ctrl_nxt[diag_pkg::BIT_START] = 1'b0;
		if (confirmed && ctrl_r[diag_pkg::BIT_START] && !eng_busy && run_sel_r == 3'b000
		    && !eng_done) begin
			go = 1'b1;
			run_sel_nxt = {ctrl_r[diag_pkg::BIT_DMA_SEL],
			               ctrl_r[diag_pkg::BIT_LOOP_SEL],
			               ctrl_r[diag_pkg::BIT_RAM_SEL]};
		end
		if (eng_done) begin
			ctrl_nxt[diag_pkg::BIT_START] = 1'b0;
			run_sel_nxt = 3'b000;
			irq_set[diag_pkg::IRQ_DIAG_DONE] = 1'b1;
		end
		case (mode_r)
			diag_pkg::MODE_ISOLATE: begin
				if (ctrl_r[diag_pkg::BIT_DIAG_EN]) begin
					mode_nxt = diag_pkg::MODE_DIAG;
					state_nxt = 1'b1;
				end
			end
			diag_pkg::MODE_DIAG: begin
				if (!ctrl_r[diag_pkg::BIT_DIAG_EN])
					mode_nxt = diag_pkg::MODE_LEAVING;
			end
			diag_pkg::MODE_LEAVING: begin
				// Wait for the running test so its memory traffic ends cleanly
				if (!eng_busy && !go && !ctrl_r[diag_pkg::BIT_START]) begin
					mode_nxt = diag_pkg::MODE_ISOLATE;
					state_nxt = 1'b0;
					irq_set[diag_pkg::IRQ_MODE_CHANGE] = 1'b1;
				end
			end
			default: begin
				mode_nxt = diag_pkg::MODE_ISOLATE;
				state_nxt = 1'b0;
			end
		endcase
		// A test still pending keeps running while leaving
		if (mode_r == diag_pkg::MODE_LEAVING && ctrl_r[diag_pkg::BIT_START] && state_r
		    && !eng_busy && run_sel_r == 3'b000 && !eng_done) begin
			go = 1'b1;
			run_sel_nxt = {ctrl_r[diag_pkg::BIT_DMA_SEL], ctrl_r[diag_pkg::BIT_LOOP_SEL],
			               ctrl_r[diag_pkg::BIT_RAM_SEL]};
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= diag_pkg::CTRL_RESET;
			mode_r <= diag_pkg::MODE_ISOLATE;
			state_r <= 1'b0;
			run_sel_r <= 3'b000;
		end else begin
			ctrl_r <= ctrl_nxt;
			mode_r <= mode_nxt;
			state_r <= state_nxt;
			run_sel_r <= run_sel_nxt;
		end
	end

	// ------------------------------------------------------------
	// Test engine and interrupts
	// ------------------------------------------------------------
	diag_test_engine #(
		.CYCLES(TEST_CYCLES)
	) u_engine (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.go(go),
		.sel(run_sel_nxt),
		.busy(eng_busy),
		.done(eng_done)
	);

	// Clear register is write only: a write pulses the clear
	always_comb begin
		irq_clr = '0;
		irq_en_nxt = irq_en_r;
		if (reg_wr && reg_addr == diag_pkg::OFS_IRQ_CLEAR)
			irq_clr = reg_wdata[diag_pkg::IRQ_WIDTH-1:0];
		if (reg_wr && reg_addr == diag_pkg::OFS_IRQ_ENABLE)
			irq_en_nxt = reg_wdata[diag_pkg::IRQ_WIDTH-1:0];
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			irq_en_r <= '0;
		else
			irq_en_r <= irq_en_nxt;
	end

	diag_irq #(
		.N(diag_pkg::IRQ_WIDTH)
	) u_irq (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.event_set(irq_set),
		.clear(irq_clr),
		.enable(irq_en_r),
		.status(irq_stat),
		.irq(irq_line)
	);
	assign mode_change_irq = irq_line; // Registered inside the irq block

	// ------------------------------------------------------------
	// Read port and pin outputs
	// ------------------------------------------------------------
	logic [7:0] rdata_r, rdata_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic oe_n_r, oe_n_nxt;
	logic diag_state_r;
	logic [2:0] run_r;

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				diag_pkg::OFS_DIAG_CONTROL: rdata_nxt = ctrl_r;
				diag_pkg::OFS_FRAME_STATUS: rdata_nxt = {frame_flags.last_frame_flag,
				                                         frame_flags.ack_pending_flag,
				                                         frame_flags.short_frame_flag, 1'b0,
				                                         frame_flags.buffer_size_field};
				diag_pkg::OFS_MODE_STATUS: rdata_nxt = {4'h0, eng_busy, 1'b0, mode_r};
				diag_pkg::OFS_IRQ_STATUS: rdata_nxt = {6'h00, irq_stat};
				diag_pkg::OFS_IRQ_ENABLE: rdata_nxt = {6'h00, irq_en_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Address pins: driven when enabled or during a grant
	always_comb begin
		addr_nxt = addr_value;
		oe_n_nxt = !(ctrl_nxt[diag_pkg::BIT_ADDR_DRV] || !dma_grant_ack_n);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
			addr_r <= 16'h0000;
			oe_n_r <= 1'b1;
			diag_state_r <= 1'b0;
			run_r <= 3'b000;
		end else begin
			rdata_r <= rdata_nxt;
			addr_r <= addr_nxt;
			oe_n_r <= oe_n_nxt;
			diag_state_r <= state_nxt;
			run_r <= run_sel_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign addr_out = addr_r;
	assign addr_oe_n = oe_n_r;
	assign diag_state = diag_state_r;
	assign test_running = run_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_start_needs_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		go |-> state_r)
		else $error("test launched without confirmed mode");

	a_done_clears_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
		eng_done |=> !ctrl_r[diag_pkg::BIT_START])
		else $error("start bit not cleared after test");

	// Each select must reach the running output one cycle after launch
	a_sel_ram: assert property (@(posedge clk_sys) disable iff (!reset_n)
		go |=> test_running[0] == $past(ctrl_r[diag_pkg::BIT_RAM_SEL]))
		else $error("ram test select not honoured");

	a_sel_loop: assert property (@(posedge clk_sys) disable iff (!reset_n)
		go |=> test_running[1] == $past(ctrl_r[diag_pkg::BIT_LOOP_SEL]))
		else $error("loop test select not honoured");

	a_sel_dma: assert property (@(posedge clk_sys) disable iff (!reset_n)
		go |=> test_running[2] == $past(ctrl_r[diag_pkg::BIT_DMA_SEL]))
		else $error("dma test select not honoured");

	a_addr_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!dma_grant_ack_n |=> !addr_oe_n)
		else $error("address not driven during grant");

	a_leave_waits: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(mode_r == diag_pkg::MODE_LEAVING && eng_busy) |=> mode_r != diag_pkg::MODE_ISOLATE)
		else $error("isolate entered while test running");

	a_isolate_event: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(mode_r == diag_pkg::MODE_LEAVING && mode_nxt == diag_pkg::MODE_ISOLATE)
		|=> irq_stat[diag_pkg::IRQ_MODE_CHANGE])
		else $error("mode change event missing");

	a_status_zero_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr == diag_pkg::OFS_FRAME_STATUS) |=> reg_rdata[4] == 1'b0
		&& reg_rdata[3:0] == $past(frame_flags.buffer_size_field))
		else $error("frame status layout wrong");

	// The state pin must agree with the mode machine at every edge
	a_mode_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
		diag_state == (mode_r != diag_pkg::MODE_ISOLATE))
		else $error("state bit disagrees with mode");

	// Without a grant the pins follow the address drive bit alone
	a_float_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
		dma_grant_ack_n |=> addr_oe_n == !ctrl_r[diag_pkg::BIT_ADDR_DRV])
		else $error("address pins driven without grant or enable");

	// The level output follows the sticky bits under the enable of the cycle before
	a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
		mode_change_irq == |(irq_stat & $past(irq_en_r)))
		else $error("interrupt level does not match enabled status");

	// An event and a clear in one cycle: the event must survive
	a_set_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(irq_set != '0) |=> (irq_stat & $past(irq_set)) == $past(irq_set))
		else $error("event lost to a clear");

	// Finishing a test drops the running select with the start bit
	a_run_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
		eng_done |=> test_running == 3'b000)
		else $error("running select kept after test end");

	// Completion is a single pulse, so one test never raises two done events
	a_done_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
		eng_done |=> !eng_done)
		else $error("done pulse longer than one cycle");

	// Reserved control bits never read back as one
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr == diag_pkg::OFS_DIAG_CONTROL) |=> reg_rdata[6:5] == 2'b00)
		else $error("reserved control bits read as one");
endmodule // token_node_diag_control
`default_nettype wire

// ===== tb/mem_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Memory side: grants the bus and walks DMA addresses
// ------------------------------------------------------------
module mem_bus_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Grant request from the bench
	input wire logic grant_go,
	input wire logic [3:0] grant_len,
	// Bus toward the block
	output logic dma_grant_ack_n,
	output logic [15:0] addr_value
);
	logic [3:0] left_r;

	// Grant lasts grant_len cycles; outside it the lines toggle so no stale value looks valid
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			left_r <= 4'h0;
			dma_grant_ack_n <= 1'b1;
			addr_value <= 16'h0000;
		end else if (grant_go) begin
			left_r <= grant_len;
			dma_grant_ack_n <= 1'b0;
			addr_value <= 16'h1000;
		end else if (left_r > 4'h1) begin
			left_r <= left_r - 4'h1;
			addr_value <= addr_value + 16'h0001;
		end else begin
			left_r <= 4'h0;
			dma_grant_ack_n <= 1'b1;
			addr_value <= ~addr_value;
		end
	end
endmodule // mem_bus_model
`default_nettype wire

// ===== tb/token_node_diag_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			bad_count++; \
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
// ------------------------------------------------------------
// Bench for the diagnostic control block
// ------------------------------------------------------------
module token_node_diag_control_test;
	localparam int RUN = 8;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	diag_pkg::frame_flags_t frame_flags = '0;
	logic grant_go = 1'b0;
	logic [3:0] grant_len = 4'h4;
	logic [7:0] reg_rdata, rd_v;
	logic dma_grant_ack_n, addr_oe_n, diag_state, mode_change_irq;
	logic [15:0] addr_value, addr_out, prev;
	logic [2:0] test_running;
	int bad_count = 0;
	int total_checks = 0;

	// Clock at 125 MHz
	always #4 clk_sys = ~clk_sys;

	token_node_diag_control #(.TEST_CYCLES(RUN)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .frame_flags(frame_flags), .addr_value(addr_value),
		.dma_grant_ack_n(dma_grant_ack_n), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
		.diag_state(diag_state), .test_running(test_running), .mode_change_irq(mode_change_irq));
	mem_bus_model mem (.clk_sys(clk_sys), .reset_n(reset_n), .grant_go(grant_go),
		.grant_len(grant_len), .dma_grant_ack_n(dma_grant_ack_n), .addr_value(addr_value));

	// ------------------------------------------------------------
	// Bus and wait helpers
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe, so it is taken there
	task automatic reg_read(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	// Which: 0 mode state, 1 running test, 2 grant line; bounded so a hang ends the run
	task automatic wait_until(input int which, input logic [2:0] want);
		int n;
		n = 0;
		while (((which == 0) ? {2'b00, diag_state} : (which == 1) ? test_running :
			{2'b00, dma_grant_ack_n}) !== want) begin
			@(posedge clk_sys);
			#1 n++;
			if (n > 60) begin
				bad_count++;
				$display("[ERR] wait %0d expected %0h seen timeout", which, want);
				wrap_up();
			end
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		`CHECK("oe_n", 1'b1, addr_oe_n)
		`CHECK("state", 1'b0, diag_state)
		reg_read(diag_pkg::OFS_DIAG_CONTROL);
		`CHECK("ctrl", 8'h00, rd_v)
		reg_read(4'hF);
		`CHECK("unmapped", 8'h00, rd_v)
	endtask
	task automatic t_status();
		logic [6:0] pat [4] = '{7'h00, 7'h4F, 7'h30, 7'h7F};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			frame_flags <= pat[i];
			reg_read(diag_pkg::OFS_FRAME_STATUS);
			`CHECK("status", {pat[i][6:4], 1'b0, pat[i][3:0]}, rd_v)
		end
		reg_write(diag_pkg::OFS_FRAME_STATUS, 8'h00);
		reg_read(diag_pkg::OFS_FRAME_STATUS);
		`CHECK("size ro", 8'hEF, rd_v)
	endtask
	// Start and selects without confirmed mode must do nothing
	task automatic t_gated();
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h6F);
		repeat (RUN + 4) begin
			@(posedge clk_sys);
			#1 `CHECK("no run", 3'b000, test_running)
		end
		reg_read(diag_pkg::OFS_DIAG_CONTROL);
		`CHECK("start res", 8'h00, rd_v & 8'h61)
		reg_read(diag_pkg::OFS_IRQ_STATUS);
		`CHECK("no done", 8'h00, rd_v)
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h00);
	endtask
	task automatic t_addr();
		`CHECK("float", 1'b1, addr_oe_n)
		@(posedge clk_sys);
		grant_go <= 1'b1;
		@(posedge clk_sys);
		grant_go <= 1'b0;
		wait_until(2, 3'b000);
		@(posedge clk_sys);
		#1 `CHECK("grant drive", 1'b0, addr_oe_n)
		wait_until(2, 3'b001);
		repeat (2) @(posedge clk_sys);
		#1 `CHECK("release", 1'b1, addr_oe_n)
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h10);
		repeat (2) @(posedge clk_sys);
		#1 `CHECK("always drive", 1'b0, addr_oe_n)
		prev = addr_value;
		@(posedge clk_sys);
		#1 `CHECK("addr", prev, addr_out)
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h00);
	endtask
	// Each select in turn; start clears itself and the done event is raised
	task automatic t_tests();
		logic [2:0] sel;
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h80);
		wait_until(0, 3'b001);
		reg_read(diag_pkg::OFS_MODE_STATUS);
		`CHECK("mode", 2'b01, rd_v[1:0])
		reg_write(diag_pkg::OFS_IRQ_ENABLE, 8'h03);
		for (int i = 0; i < 3; i++) begin
			sel = 3'b001 << i;
			reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h81 | {4'h0, sel, 1'b0});
			@(posedge clk_sys);
			#1 `CHECK("select", sel, test_running)
			wait_until(1, 3'b000);
			reg_read(diag_pkg::OFS_DIAG_CONTROL);
			`CHECK("start clr", 1'b0, rd_v[0])
			reg_read(diag_pkg::OFS_IRQ_STATUS);
			`CHECK("done", 1'b1, rd_v[1])
			reg_write(diag_pkg::OFS_IRQ_CLEAR, 8'h02);
		end
	endtask
	// Leave mode mid-test, then raise, mask and clear the interrupt
	task automatic t_leave();
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h89);
		wait_until(1, 3'b100);
		reg_write(diag_pkg::OFS_DIAG_CONTROL, 8'h00);
		#1 `CHECK("stay", 1'b1, diag_state)
		reg_read(diag_pkg::OFS_MODE_STATUS);
		`CHECK("leaving", 8'h0A, rd_v)
		wait_until(0, 3'b000);
		`CHECK("finished", 3'b000, test_running)
		reg_read(diag_pkg::OFS_IRQ_STATUS);
		`CHECK("mode evt", 1'b1, rd_v[0])
		`CHECK("irq", 1'b1, mode_change_irq)
		reg_write(diag_pkg::OFS_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1 `CHECK("masked", 1'b0, mode_change_irq)
		reg_write(diag_pkg::OFS_IRQ_ENABLE, 8'h01);
		repeat (2) @(posedge clk_sys);
		#1 `CHECK("unmasked", 1'b1, mode_change_irq)
		reg_write(diag_pkg::OFS_IRQ_CLEAR, 8'h03);
		repeat (2) @(posedge clk_sys);
		#1 `CHECK("cleared", 1'b0, mode_change_irq)
		reg_read(diag_pkg::OFS_IRQ_STATUS);
		`CHECK("status clr", 8'h00, rd_v)
	endtask

	// Main sequence: reset held for four cycles
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1 t_reset();
		t_status();
		t_gated();
		t_addr();
		t_tests();
		t_leave();
		wrap_up();
	end
	// Overall guard against a stuck run
	initial begin
		#400000 bad_count++;
		wrap_up();
	end
endmodule // token_node_diag_control_test
`default_nettype wire
